/* hsm_regs.svh */
// constants for the hall sensor measurement sequencer
// Function
// - host is the bus master; the device only answers as a slave.
// - after power-on, bias and oscillator stay off in low-power, waiting for setup.
// - each change of temperature, continuous or wake enable starts a cycle: supply check, bias and oscillator together, hall bias.
// - convert X, Y, Z in turn through one converter, then return to configured mode.
// - optional temperature conversion after the three axes, enabled by default.
// - axis results are 12 bits, temperature result is 10 bits.
// - low supply stalls the sequencer; it restarts from the beginning once good.
// - a bus reset command mid-cycle abandons the cycle and drops any pending run.
// - each axis has its own upper and lower threshold, compared every cycle.
// - with wake enabled, a component outside its window pulses the alert; inside, no pulse.
// - the alert is the OR of the three per-axis window violations.
// - with collision avoidance on, the alert pulse is skipped when the bus is busy at evaluation.
// - with wake disabled, cycle completion is signalled on the active-low open-drain alert.
// - data line is open-drain two-way; the bus clock is an input only.
// - alert wired to the bus clock holds it low to stretch transfers.
// - a bus command triggers a measurement cycle.
`ifndef HSM_REGS_SVH
`define HSM_REGS_SVH

// fast clock rate
`define HSM_CLK_MHZ      125
// settle times in ns and derived cycle counts, rounded up
`define HSM_BIAS_NS      2000
`define HSM_BIAS_CYC     ((`HSM_BIAS_NS * `HSM_CLK_MHZ + 999) / 1000)
`define HSM_HALL_NS      1000
`define HSM_HALL_CYC     ((`HSM_HALL_NS * `HSM_CLK_MHZ + 999) / 1000)
// alert pulse length, rounded down
`define HSM_PULSE_NS     1000
`define HSM_PULSE_CYC    ((`HSM_PULSE_NS * `HSM_CLK_MHZ) / 1000)
// latest low-phase age, in fast cycles, at which a clock stretch may begin
`define HSM_STR_WIN      3'h3
// bus slave address (arbitrary) and command bytes
`define HSM_SLV_ADDR     7'h35
`define HSM_CMD_TRIG     8'h01
`define HSM_CMD_RESET    8'hFF
// converter channel codes
`define HSM_CH_X         2'h0
`define HSM_CH_Y         2'h1
`define HSM_CH_Z         2'h2
`define HSM_CH_TEMP      2'h3

`endif

/* hsm_pkg.sv */
// types shared by the hall sensor measurement sequencer
package hsm_pkg;
	typedef logic signed [11:0] hsm_axis_type;
	typedef logic [9:0]         hsm_temp_type;
	typedef logic [7:0]         hsm_cnt_type;
	// sequencer states, gray along the usual path except the return from HSM_RESUME
	typedef enum logic [2:0] {
		HSM_LOWPWR = 3'h0,
		HSM_BIAS   = 3'h1,
		HSM_HBIAS  = 3'h3,
		HSM_CONV   = 3'h2,
		HSM_WAIT   = 3'h6,
		HSM_EVAL   = 3'h7,
		HSM_RESUME = 3'h5
	} hsm_seq_type;
	// bus slave states
	typedef enum logic [2:0] {
		HSM_I_IDLE = 3'h0,
		HSM_I_ADDR = 3'h1,
		HSM_I_AACK = 3'h3,
		HSM_I_DATA = 3'h2,
		HSM_I_DACK = 3'h6
	} hsm_i2c_type;
endpackage : hsm_pkg

/* hsm_link_if.sv */
// link-domain events handed from the bus slave to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface hsm_link_if;
	logic trig_tgl;  // toggles per trigger command
	logic rst_tgl;   // toggles per bus reset command
	logic busy;      // level: bus transfer in progress
	modport slave (output trig_tgl, output rst_tgl, output busy);
	modport seq   (input trig_tgl, input rst_tgl, input busy);
endinterface : hsm_link_if
`default_nettype wire

/* hsm_sync.sv */
// three-stage synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hsm_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// data
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, q_d;

	// take each bit only once the last two stages match
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : o_q[i];
		end
	end

	// first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			o_q  <= '0;
		end else begin
			s1_q <= i_d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			o_q  <= q_d;
		end
	end
endmodule : hsm_sync
`default_nettype wire

/* hsm_i2c_slave.sv */
// write-only bus slave on the link clock, decodes trigger and reset commands
`timescale 1ns/1ps
`default_nettype none
`include "hsm_regs.svh"
module hsm_i2c_slave
	import hsm_pkg::*;
(
	// link clock and reset
	input  wire logic   i_link_clk,
	input  wire logic   i_rstn,
	// bus pins
	input  wire logic   i_scl,
	input  wire logic   i_sda,
	output logic        o_sda_o,
	output logic        o_sda_oe,
	// events toward the sequencer
	hsm_link_if.slave   lnk
);
	logic        scl_s, sda_s, scl_p_q, sda_p_q;
	hsm_i2c_type st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic        oe_d, trig_d, rst_d, busy_d;
	logic        rise, fall, start, stop;

	// pins are asynchronous to the link clock
	hsm_sync #(.WIDTH(2)) u_pin_sync (
		.i_clk  (i_link_clk),
		.i_rstn (i_rstn),
		.i_d    ({i_scl, i_sda}),
		.o_q    ({scl_s, sda_s})
	);

	assign rise  = scl_s & ~scl_p_q;
	assign fall  = ~scl_s & scl_p_q;
	assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// protocol decode; device never drives the clock line
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		oe_d   = o_sda_oe;
		trig_d = lnk.trig_tgl;
		rst_d  = lnk.rst_tgl;
		busy_d = lnk.busy;
		if (start) begin
			st_d   = HSM_I_ADDR;
			cnt_d  = 4'h0;
			oe_d   = 1'b0;
			busy_d = 1'b1;
		end else if (stop) begin
			st_d   = HSM_I_IDLE;
			oe_d   = 1'b0;
			busy_d = 1'b0;
		end else if (rise && (st_q == HSM_I_ADDR || st_q == HSM_I_DATA)
				&& cnt_q != 4'h8) begin
			sh_d  = {sh_q[6:0], sda_s};
			cnt_d = cnt_q + 4'h1;
		end else if (fall) begin
			case (st_q)
				HSM_I_ADDR: begin
					if (cnt_q == 4'h8) begin
						// only write accesses to our address are acknowledged
						if (sh_q[7:1] == `HSM_SLV_ADDR && !sh_q[0]) begin
							st_d = HSM_I_AACK;
							oe_d = 1'b1;
						end else begin
							st_d = HSM_I_IDLE;
						end
					end
				end
				HSM_I_DATA: begin
					if (cnt_q == 4'h8) begin
						st_d = HSM_I_DACK;
						oe_d = 1'b1;
						if (sh_q == `HSM_CMD_TRIG) begin
							trig_d = ~lnk.trig_tgl;
						end else if (sh_q == `HSM_CMD_RESET) begin
							rst_d = ~lnk.rst_tgl;
						end
					end
				end
				HSM_I_AACK, HSM_I_DACK: begin
					st_d  = HSM_I_DATA;
					oe_d  = 1'b0;
					cnt_d = 4'h0;
				end
				default: begin
					st_d = HSM_I_IDLE;
				end
			endcase
		end
	end

	// register the slave state
	always_ff @(posedge i_link_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q         <= HSM_I_IDLE;
			cnt_q        <= 4'h0;
			sh_q         <= 8'h00;
			scl_p_q      <= 1'b0;  // match the synchroniser, no false edge
			sda_p_q      <= 1'b0;
			o_sda_oe     <= 1'b0;
			o_sda_o      <= 1'b0;
			lnk.trig_tgl <= 1'b0;
			lnk.rst_tgl  <= 1'b0;
			lnk.busy     <= 1'b0;
		end else begin
			st_q         <= st_d;
			cnt_q        <= cnt_d;
			sh_q         <= sh_d;
			scl_p_q      <= scl_s;
			sda_p_q      <= sda_s;
			o_sda_oe     <= oe_d;
			o_sda_o      <= 1'b0;  // open-drain: only ever pulls low
			lnk.trig_tgl <= trig_d;
			lnk.rst_tgl  <= rst_d;
			lnk.busy     <= busy_d;
		end
	end
endmodule : hsm_i2c_slave
`default_nettype wire

/* hsm_top.sv */
// hall sensor measurement sequencer with window wake-up alert
`timescale 1ns/1ps
`default_nettype none
`include "hsm_regs.svh"
module hsm_top
	import hsm_pkg::*;
(
	// fast clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_rstn,
	// link clock and bus pins
	input  wire logic               i_link_clk,
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	output logic                    o_sda_o,
	output logic                    o_sda_oe,
	// alert pin, open-drain active low
	output logic                    o_int_o,
	output logic                    o_int_oe,
	// configuration
	input  wire logic               i_temp_en,
	input  wire logic               i_cont_mode,
	input  wire logic               i_wake_en,
	input  wire logic               i_coll_avoid,
	input  wire logic               i_stretch_en,
	input  wire logic [2:0][11:0]   i_thr_hi,
	input  wire logic [2:0][11:0]   i_thr_lo,
	// analog front end
	input  wire logic               i_supply_ok,
	input  wire logic               i_adc_done,
	input  wire logic [11:0]        i_adc_data,
	output logic                    o_bias_en,
	output logic                    o_fosc_en,
	output logic                    o_hall_bias_en,
	output logic                    o_adc_start,
	output logic [1:0]              o_adc_ch,
	// results and status
	output logic [2:0][11:0]        o_axis,
	output logic [9:0]              o_temp,
	output logic                    o_done,
	output logic                    o_wake,
	output logic                    o_meas_busy
);
	hsm_link_if  lnk ();
	logic        sup_ok, trig_s, rst_s, busy_s;
	logic        trig_p_q, rst_p_q;
	logic        trig_ev, rst_ev, cfg_ev;
	logic [2:0]  cfg_q;
	hsm_seq_type st_q, st_d;
	logic [1:0]  ch_q, ch_d;
	hsm_cnt_type cnt_q, cnt_d;
	hsm_cnt_type pls_q, pls_d;
	logic        pend_q, pend_d;
	logic [2:0]  out_win;
	logic        wake_any, int_oe_d, start_d, done_d, wake_d;
	logic        meas_d, bias_d, hbias_d;
	hsm_axis_type res_q [3];
	hsm_axis_type res_d [3];
	hsm_temp_type temp_q, temp_d;
	// stretch tracking: bus clock level, low-phase age, hold
	logic        scl_lvl, stretch_q, stretch_d;
	logic [2:0]  lowc_q, lowc_d;

	// bus slave in the link domain
	hsm_i2c_slave u_slave (
		.i_link_clk (i_link_clk),
		.i_rstn     (i_rstn),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_o    (o_sda_o),
		.o_sda_oe   (o_sda_oe),
		.lnk        (lnk.slave)
	);

	// toggles and busy level cross into the fast domain
	hsm_sync #(.WIDTH(3)) u_link_sync (
		.i_clk  (i_sys_clk),
		.i_rstn (i_rstn),
		.i_d    ({lnk.trig_tgl, lnk.rst_tgl, lnk.busy}),
		.o_q    ({trig_s, rst_s, busy_s})
	);

	// supply monitor is analog and asynchronous
	hsm_sync #(.WIDTH(1)) u_sup_sync (
		.i_clk  (i_sys_clk),
		.i_rstn (i_rstn),
		.i_d    (i_supply_ok),
		.o_q    (sup_ok)
	);

	// bus clock level as seen by the fast domain; the pin is asynchronous
	// and also carries our own alert when the two are wired together
	hsm_sync #(.WIDTH(1)) u_scl_sync (
		.i_clk  (i_sys_clk),
		.i_rstn (i_rstn),
		.i_d    (i_scl),
		.o_q    (scl_lvl)
	);

	// events: command toggles and configuration changes
	// a toggle per command survives the crossing where a pulse might not
	assign trig_ev = trig_s ^ trig_p_q;
	assign rst_ev  = rst_s ^ rst_p_q;
	assign cfg_ev  = cfg_q != {i_temp_en, i_cont_mode, i_wake_en};

	// per-axis window check on the stored signed results
	always_comb begin
		for (int a = 0; a < 3; a++) begin
			out_win[a] = (res_q[a] > $signed(i_thr_hi[a]))
				|| (res_q[a] < $signed(i_thr_lo[a]));
		end
	end
	assign wake_any = |out_win;

	// sequencer next state
	always_comb begin
		st_d    = st_q;
		ch_d    = ch_q;
		cnt_d   = cnt_q;
		pend_d  = pend_q;
		res_d   = res_q;
		temp_d  = temp_q;
		start_d = 1'b0;
		done_d  = 1'b0;
		wake_d  = o_wake;
		pls_d   = (pls_q != 8'h00) ? pls_q - 8'h01 : pls_q;
		case (st_q)
			HSM_LOWPWR: begin
				// wait here for setup or a trigger
				if (pend_q && sup_ok) begin
					st_d   = HSM_BIAS;
					pend_d = 1'b0;
					cnt_d  = hsm_cnt_type'(`HSM_BIAS_CYC);
				end
			end
			HSM_BIAS: begin
				// internal bias and oscillator settle
				if (cnt_q == 8'h00) begin
					st_d  = HSM_HBIAS;
					cnt_d = hsm_cnt_type'(`HSM_HALL_CYC);
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			HSM_HBIAS: begin
				if (cnt_q == 8'h00) begin
					st_d = HSM_CONV;
					ch_d = `HSM_CH_X;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			HSM_CONV: begin
				start_d = 1'b1;
				st_d    = HSM_WAIT;
			end
			HSM_WAIT: begin
				if (i_adc_done) begin
					if (ch_q == `HSM_CH_TEMP) begin
						temp_d = i_adc_data[9:0];
						st_d   = HSM_EVAL;
					end else begin
						res_d[ch_q] = i_adc_data;
						if (ch_q != `HSM_CH_Z) begin
							ch_d = ch_q + 2'h1;
							st_d = HSM_CONV;
						end else if (i_temp_en) begin
							ch_d = `HSM_CH_TEMP;
							st_d = HSM_CONV;
						end else begin
							st_d = HSM_EVAL;
						end
					end
				end
			end
			HSM_EVAL: begin
				// one comparison per cycle, after the last conversion
				done_d = 1'b1;
				wake_d = wake_any;
				st_d   = HSM_RESUME;
				if ((!i_wake_en || wake_any) && !(i_coll_avoid && busy_s)) begin
					pls_d = hsm_cnt_type'(`HSM_PULSE_CYC);
				end
			end
			HSM_RESUME: begin
				st_d = HSM_LOWPWR;
				if (i_cont_mode) begin
					pend_d = 1'b1;
				end
			end
			default: begin
				st_d = HSM_LOWPWR;
			end
		endcase
		// low supply abandons the cycle and queues a rerun
		if (!sup_ok && st_q != HSM_LOWPWR) begin
			st_d    = HSM_LOWPWR;
			pend_d  = 1'b1;
			start_d = 1'b0;
			done_d  = 1'b0;
			pls_d   = pls_q;
		end
		// bus reset drops the cycle and any pending run; new requests win over the clear
		if (rst_ev) begin
			st_d    = HSM_LOWPWR;
			pend_d  = 1'b0;
			start_d = 1'b0;
			done_d  = 1'b0;
		end
		if (trig_ev || cfg_ev) begin
			pend_d = 1'b1;
		end
	end

	// clock stretch: a slave may only keep the bus clock low, never cut a
	// high phase short, so the hold begins early in a low phase or waits
	// for the next one; it ends with the cycle so the host can finish
	always_comb begin
		lowc_d    = lowc_q;
		stretch_d = stretch_q;
		// fast cycles since the bus clock was last seen high
		if (scl_lvl) begin
			lowc_d = 3'h0;
		end else if (lowc_q != 3'h7) begin
			lowc_d = lowc_q + 3'h1;
		end
		// a finished or disabled cycle lets the clock go at once
		if (!i_stretch_en || !meas_d) begin
			stretch_d = 1'b0;
		end else if (busy_s && !scl_lvl && lowc_q <= `HSM_STR_WIN) begin
			stretch_d = 1'b1;
		end
	end

	// front-end controls and alert drive
	always_comb begin
		meas_d   = st_d != HSM_LOWPWR;
		bias_d   = meas_d;
		hbias_d  = st_d == HSM_HBIAS || st_d == HSM_CONV || st_d == HSM_WAIT;
		// holding the alert low during a transfer stretches the clock;
		// the hold and the alert pulse share the one pin
		int_oe_d = (pls_d != 8'h00)
			|| stretch_d;
	end

	// register everything
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q           <= HSM_LOWPWR;
			ch_q           <= `HSM_CH_X;
			cnt_q          <= 8'h00;
			pls_q          <= 8'h00;
			pend_q         <= 1'b0;
			lowc_q         <= 3'h0;
			stretch_q      <= 1'b0;
			trig_p_q       <= 1'b0;
			rst_p_q        <= 1'b0;
			cfg_q          <= 3'h0;
			temp_q         <= 10'h000;
			res_q          <= '{default: 12'sh000};
			o_int_o        <= 1'b0;
			o_int_oe       <= 1'b0;
			o_bias_en      <= 1'b0;
			o_fosc_en      <= 1'b0;
			o_hall_bias_en <= 1'b0;
			o_adc_start    <= 1'b0;
			o_adc_ch       <= `HSM_CH_X;
			o_axis         <= '0;
			o_temp         <= 10'h000;
			o_done         <= 1'b0;
			o_wake         <= 1'b0;
			o_meas_busy    <= 1'b0;
		end else begin
			st_q           <= st_d;
			ch_q           <= ch_d;
			cnt_q          <= cnt_d;
			pls_q          <= pls_d;
			pend_q         <= pend_d;
			lowc_q         <= lowc_d;
			stretch_q      <= stretch_d;
			trig_p_q       <= trig_s;
			rst_p_q        <= rst_s;
			cfg_q          <= {i_temp_en, i_cont_mode, i_wake_en};
			temp_q         <= temp_d;
			res_q          <= res_d;
			o_int_o        <= 1'b0;   // open-drain: only pulls low
			o_int_oe       <= int_oe_d;
			o_bias_en      <= bias_d;
			o_fosc_en      <= bias_d;
			o_hall_bias_en <= hbias_d;
			o_adc_start    <= start_d;
			o_adc_ch       <= ch_d;
			for (int a = 0; a < 3; a++) begin
				o_axis[a] <= res_d[a];
			end
			o_temp         <= temp_d;
			o_done         <= done_d;
			o_wake         <= wake_d;
			o_meas_busy    <= meas_d;
		end
	end
endmodule : hsm_top
`default_nettype wire

/* hsm_top_properties.sv */
// port-level assertions for the hall sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hsm_regs.svh"
module hsm_top_properties (
	// clock, reset and configuration
	input wire logic             i_sys_clk,
	input wire logic             i_rstn,
	input wire logic             i_temp_en,
	input wire logic             i_wake_en,
	input wire logic             i_coll_avoid,
	input wire logic             i_stretch_en,
	input wire logic             i_supply_ok,
	input wire logic [2:0][11:0] i_thr_hi,
	input wire logic [2:0][11:0] i_thr_lo,
	// outputs watched
	input wire logic             o_sda_o,
	input wire logic             o_int_o,
	input wire logic             o_int_oe,
	input wire logic             o_bias_en,
	input wire logic             o_fosc_en,
	input wire logic             o_hall_bias_en,
	input wire logic             o_adc_start,
	input wire logic [1:0]       o_adc_ch,
	input wire logic [2:0][11:0] o_axis,
	input wire logic             o_done
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	localparam int PULSE = `HSM_PULSE_CYC;
	logic [7:0] run_q, run_d;
	logic [1:0] ch_q, ch_d;
	logic       out_w;
	// window flag, alert high-time count, last channel started
	always_comb begin
		out_w = 1'b0;
		for (int i = 0; i < 3; i++)
			out_w |= $signed(o_axis[i]) > $signed(i_thr_hi[i]) || $signed(o_axis[i]) < $signed(i_thr_lo[i]);
		run_d = o_int_oe ? run_q + 8'h01 : 8'h00;
		ch_d = o_adc_start ? o_adc_ch : ch_q;
	end
	// helper registers, cleared with the design
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_q <= 8'h00;
			ch_q <= 2'h0;
		end else begin
			run_q <= run_d;
			ch_q <= ch_d;
		end
	end
	a_sda_pull_only: assert property (o_sda_o == 1'b0) else $error("sda driven high");
	a_int_pull_only: assert property (o_int_o == 1'b0) else $error("alert driven high");
	a_bias_with_osc: assert property (o_bias_en |-> o_fosc_en) else $error("osc off");
	a_hall_after_bias: assert property ($rose(o_hall_bias_en) |-> $past(o_bias_en, 200))
		else $error("hall bias too early");
	a_start_in_hall: assert property (o_adc_start |-> o_hall_bias_en) else $error("start unbiased");
	a_chan_order: assert property (o_adc_start && o_adc_ch != 2'h0 |->
		o_adc_ch == ch_q + 2'h1 && (o_adc_ch != 2'h3 || i_temp_en)) else $error("channel order");
	a_supply_stall: assert property ((!i_supply_ok) [*8] |-> !o_bias_en && !o_adc_start)
		else $error("runs on low supply");
	a_pulse_len: assert property ($fell(o_int_oe) && !i_stretch_en |-> run_q == PULSE)
		else $error("alert pulse length");
	a_alert_on_done: assert property (o_done && !i_coll_avoid && (!i_wake_en || out_w) |->
		##[0:2] o_int_oe) else $error("alert missing");
	a_quiet_inside: assert property (o_done && i_wake_en && !out_w && !i_stretch_en |->
		(!o_int_oe) [*3]) else $error("alert inside window");
endmodule : hsm_top_properties
bind hsm_top hsm_top_properties u_props (.*);
`default_nettype wire

/* hsm_host_model.sv */
// bus master model pulling the open-drain bus lines
`timescale 1ns/1ps
`default_nettype none
module hsm_host_model (
	// link clock and line levels
	input wire logic i_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	// pull-down requests
	output logic     o_scl_low,
	output logic     o_sda_low
);
	localparam int Q = 6;
	logic stretched;
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
		stretched = 1'b0;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
	endtask : tick
	// release clock; a slave may hold it low, bounded wait
	task automatic scl_up();
		int w;
		o_scl_low <= 1'b0;
		w = 0;
		tick(1);
		while (i_scl !== 1'b1 && w < 4000) begin
			tick(1);
			w++;
		end
		if (w > 16) stretched = 1'b1;
		tick(Q);
	endtask : scl_up
	// data changes only while clock is low
	task automatic bit_io(input logic b, output logic s);
		o_sda_low <= !b;
		tick(Q);
		scl_up();
		s = i_sda;
		o_scl_low <= 1'b1;
		tick(1);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask : byte_io
	// host always masters: start, address, data if a write is acked, stop
	task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] v,
		output logic ack_a, output logic ack_d);
		o_sda_low <= 1'b0;
		scl_up();
		o_sda_low <= 1'b1;
		tick(Q);
		o_scl_low <= 1'b1;
		tick(1);
		byte_io({a, rw}, ack_a);
		ack_d = 1'b0;
		if (ack_a && !rw) byte_io(v, ack_d);
		o_sda_low <= 1'b1;
		tick(Q);
		scl_up();
		o_sda_low <= 1'b0;
		tick(Q);
	endtask : xfer
endmodule : hsm_host_model
`default_nettype wire

/* hsm_top_tb.sv */
// self-checking bench for hsm_top
`timescale 1ns/1ps
`default_nettype none
`include "hsm_regs.svh"
module hsm_top_tb;
	import hsm_pkg::*;
	typedef struct packed {
		logic [2:0][11:0] ax;
		logic [9:0]       t;
		logic             irq;
		logic             wk;
	} hsm_note_type;
	logic i_sys_clk, i_rstn, i_link_clk, i_temp_en, i_cont_mode, i_wake_en;
	logic i_coll_avoid, i_stretch_en, i_supply_ok, i_adc_done, h_scl, h_sda;
	logic [11:0] i_adc_data, d;
	logic [2:0][11:0] i_thr_hi, i_thr_lo, o_axis;
	logic o_sda_o, o_sda_oe, o_int_o, o_int_oe, o_bias_en, o_fosc_en, o_hall_bias_en;
	logic o_adc_start, o_done, o_wake, o_meas_busy, ins, quiet, aa, ad, seen, o;
	logic [1:0] o_adc_ch, ch;
	logic [9:0] o_temp;
	wire logic i_scl, i_sda;
	int errors, check_count, dones, exp_dones, cyc, seed;
	hsm_note_type q[$];
	hsm_note_type acc, n;
	// pulled-up lines; alert wired onto the bus clock
	assign i_scl = !(h_scl || o_int_oe);
	assign i_sda = !(h_sda || o_sda_oe);
	hsm_top u_dut (.*);
	hsm_host_model u_host (.i_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda),
		.o_scl_low(h_scl), .o_sda_low(h_sda));
	initial begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = !i_sys_clk;
	end
	// link clock, phase unrelated to the fast clock
	initial begin
		i_link_clk = 1'b0;
		#3.1;
		forever #7.5 i_link_clk = !i_link_clk;
	end
	task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	// cycle ceiling against hangs
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic wait_done();
		exp_dones++;
		for (int w = 0; w < 20000 && dones < exp_dones; w++) @(negedge i_sys_clk);
		cmp("done count", 12'(exp_dones), 12'(dones));
		repeat (200) @(negedge i_sys_clk);
	endtask : wait_done
	task automatic trig(input logic [6:0] a, input logic rw, input logic [7:0] v,
		input logic ea, input logic ed);
		u_host.xfer(a, rw, v, aa, ad);
		cmp("addr ack", 12'(ea), 12'(aa));
		cmp("data ack", 12'(ed), 12'(ad));
	endtask : trig
	// note the expected outcome once the last conversion is answered
	task automatic note();
		o = 1'b0;
		for (int i = 0; i < 3; i++)
			o |= $signed(acc.ax[i]) > $signed(i_thr_hi[i]) || $signed(acc.ax[i]) < $signed(i_thr_lo[i]);
		acc.wk = o;
		acc.irq = !quiet && (!i_wake_en || o);
		q.push_back(acc);
	endtask : note
	// converter model; an abandoned start gets no answer
	always @(negedge i_sys_clk) begin
		if (o_adc_start === 1'b1) begin
			ch = o_adc_ch;
			if (ch == 2'h0) ins = 1'($urandom_range(1, 0));
			d = ins ? 12'($urandom_range(60, 0)) - 12'h01E : 12'($urandom);
			repeat ($urandom_range(12, 1)) @(negedge i_sys_clk);
			if (o_meas_busy === 1'b1) begin
				i_adc_data = d;
				i_adc_done = 1'b1;
				@(negedge i_sys_clk);
				i_adc_done = 1'b0;
				if (ch == 2'h3) acc.t = d[9:0];
				else acc.ax[ch] = d;
				if (ch == 2'h3 || (ch == 2'h2 && !i_temp_en)) note();
			end
		end
	end
	// result watcher: oldest note against each finished cycle
	always @(negedge i_sys_clk) begin
		if (o_done === 1'b1) begin
			dones++;
			cmp("note queued", 12'h001, 12'(q.size() > 0));
			n = q.size() > 0 ? q.pop_front() : acc;
			for (int i = 0; i < 3; i++) cmp("axis", n.ax[i], o_axis[i]);
			cmp("temp", 12'(n.t), 12'(o_temp));
			seen = 1'b0;
			repeat (3) @(negedge i_sys_clk) seen |= o_int_oe;
			cmp("alert", 12'(n.irq), 12'(seen));
			if (i_wake_en) cmp("wake", 12'(n.wk), 12'(o_wake));
		end
	end
	initial begin
		seed = $urandom(32'h6503);
		{i_rstn, i_adc_done, i_cont_mode, i_wake_en, i_coll_avoid, i_stretch_en} = '0;
		{i_temp_en, i_supply_ok, quiet, i_adc_data, acc} = '0;
		i_temp_en = 1'b1;
		i_supply_ok = 1'b1;
		for (int i = 0; i < 3; i++) begin
			i_thr_hi[i] = 12'h028 * 12'(i + 1);
			i_thr_lo[i] = -i_thr_hi[i];
		end
		repeat (16) @(negedge i_sys_clk);
		i_rstn = 1'b1;
		wait_done();
		trig(`HSM_SLV_ADDR, 1'b0, `HSM_CMD_TRIG, 1'b1, 1'b1);
		wait_done();
		trig(7'h2A, 1'b0, `HSM_CMD_TRIG, 1'b0, 1'b0);
		trig(`HSM_SLV_ADDR, 1'b1, 8'h00, 1'b0, 1'b0);
		trig(`HSM_SLV_ADDR, 1'b0, 8'h5A, 1'b1, 1'b1);
		trig(`HSM_SLV_ADDR, 1'b0, `HSM_CMD_RESET, 1'b1, 1'b1);
		repeat (800) @(negedge i_sys_clk);
		i_wake_en = 1'b1;
		wait_done();
		for (int k = 0; k < 10; k++) begin
			trig(`HSM_SLV_ADDR, 1'b0, `HSM_CMD_TRIG, 1'b1, 1'b1);
			wait_done();
		end
		// bus kept busy across evaluation with collision avoidance
		i_coll_avoid = 1'b1;
		quiet = 1'b1;
		fork
			repeat (3) trig(`HSM_SLV_ADDR, 1'b1, 8'h00, 1'b0, 1'b0);
			begin
				repeat (330) @(negedge i_sys_clk);
				i_temp_en = 1'b0;
			end
		join
		wait_done();
		quiet = 1'b0;
		i_coll_avoid = 1'b0;
		i_wake_en = 1'b0;
		wait_done();
		i_stretch_en = 1'b1;
		trig(`HSM_SLV_ADDR, 1'b0, `HSM_CMD_TRIG, 1'b1, 1'b1);
		cmp("stretch", 12'h001, 12'(u_host.stretched));
		wait_done();
		i_stretch_en = 1'b0;
		i_temp_en = 1'b1;
		for (int w = 0; w < 2000 && !(o_adc_start === 1'b1 && o_adc_ch === 2'h1); w++)
			@(negedge i_sys_clk);
		i_supply_ok = 1'b0;
		repeat (30) @(negedge i_sys_clk);
		i_supply_ok = 1'b1;
		wait_done();
		i_cont_mode = 1'b1;
		repeat (3) wait_done();
		i_cont_mode = 1'b0;
		repeat (3000) @(negedge i_sys_clk);
		cmp("notes left", 12'h000, 12'(q.size()));
		cmp("busy idle", 12'h000, 12'(o_meas_busy));
		end_of_test();
	end
endmodule : hsm_top_tb
`default_nettype wire
